// >>> core/epb_map.svh
// Purpose: Shared widths, depths and fixed levels of the external port bus ends
// Assumes: Included by bare name from every design file except the package
// Notes: Definitions only
`ifndef EPB_MAP_SVH
`define EPB_MAP_SVH
`define EPB_ADDR_W 32
`define EPB_DATA_W 64
`define EPB_LOW_W 32
`define EPB_FIFO_DEPTH 32
`define EPB_MEM_WORDS 16
`define EPB_STRAP_REQ 1'b1
`define EPB_STROBE_ON 1'b0
`define EPB_STROBE_OFF 1'b1
`endif

// >>> core/epb_pkg.sv
// Purpose: Types shared by both bus ends
// Assumes: Nothing
// Notes: States are binary coded
package epb_pkg;
  // Master sequencer of the processor end
  typedef enum logic [1:0] {
    EPB_DEV_IDLE = 2'h0,
    EPB_DEV_STROBE = 2'h1,
    EPB_DEV_GAP = 2'h2
  } epb_dev_state_e;
  // Sequencer of the host end
  typedef enum logic [1:0] {
    EPB_HOST_IDLE = 2'h0,
    EPB_HOST_STROBE = 2'h1,
    EPB_HOST_WAIT = 2'h2
  } epb_host_state_e;
endpackage

// >>> core/epb_if.sv
// Purpose: Shared external port wires between the processor end and the host end
// Assumes: At most one end enables a given group at a time
// Notes: Undriven strobes float to their pull-up level, address and data to zero
`include "epb_map.svh"
`timescale 1ns/1ps
`default_nettype none
interface epb_if;
  // Processor end drivers
  logic [`EPB_ADDR_W-1:0] dev_addr_o;
  logic dev_addr_oe;
  logic [`EPB_DATA_W-1:0] dev_data_o;
  logic dev_data_oe;
  logic dev_rd_n_o;
  logic dev_wrl_n_o;
  logic dev_ctl_oe;
  // Host end drivers
  logic [`EPB_ADDR_W-1:0] host_addr_o;
  logic host_addr_oe;
  logic [`EPB_DATA_W-1:0] host_data_o;
  logic host_data_oe;
  logic host_rd_n_o;
  logic host_wrl_n_o;
  logic host_ctl_oe;
  // Resolved wire levels
  logic [`EPB_ADDR_W-1:0] bus_address;
  logic [`EPB_DATA_W-1:0] bus_data;
  logic rd_n;
  logic write_low_strobe_n;

  // Wire resolution from the enables
  assign bus_address = dev_addr_oe ? dev_addr_o : (host_addr_oe ? host_addr_o : '0);
  assign bus_data = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : '0);
  assign rd_n = dev_ctl_oe ? dev_rd_n_o : (host_ctl_oe ? host_rd_n_o : `EPB_STROBE_OFF);
  assign write_low_strobe_n = dev_ctl_oe ? dev_wrl_n_o :
                              (host_ctl_oe ? host_wrl_n_o : `EPB_STROBE_OFF);

  modport dev (
    output dev_addr_o, dev_addr_oe, dev_data_o, dev_data_oe,
    output dev_rd_n_o, dev_wrl_n_o, dev_ctl_oe,
    input bus_address, bus_data, rd_n, write_low_strobe_n
  );
  modport host (
    output host_addr_o, host_addr_oe, host_data_o, host_data_oe,
    output host_rd_n_o, host_wrl_n_o, host_ctl_oe,
    input bus_address, bus_data, rd_n, write_low_strobe_n
  );
endinterface
`default_nettype wire

// >>> core/epb_dev.sv
// Purpose: Processor end of the external port, bus master and slave
// Assumes: core_clk is the system clock; the grant input may be asynchronous
// Notes: Outbound requests queue in a FIFO that drains only while the bus is owned
`include "epb_map.svh"
`timescale 1ns/1ps
`default_nettype none
module epb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `EPB_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic in_ready;
    logic out_valid;
  } epb_fifo_s;
  epb_fifo_s s;
  epb_fifo_s next_s;
  logic push;
  logic pop;
  logic [AW:0] fill;

  // Depth must be a power of two for wrapping pointers
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
    $error("epb_fifo: DEPTH must be a power of two of at least 2");
  end

  assign in_ready = s.in_ready;
  assign out_valid = s.out_valid;
  assign out_data = s.mem[s.rp[AW-1:0]];

  // Pointer update and honest full and empty flags
  always_comb begin
    next_s = s;
    push = in_valid & s.in_ready;
    pop = out_ready & s.out_valid;
    if (push) begin
      next_s.mem[s.wp[AW-1:0]] = in_data;
    end
    next_s.wp = s.wp + {{AW{1'b0}}, push};
    next_s.rp = s.rp + {{AW{1'b0}}, pop};
    fill = next_s.wp - next_s.rp;
    next_s.out_valid = (fill != '0);
    next_s.in_ready = (fill != DEPTH[AW:0]);
  end

  // State register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// Behaviour
// [RULE_01] Synchronise asynchronous inputs before use
// [RULE_02] Release all pins during reset
// [RULE_03] Reset forces idle, known state
// [RULE_04] Strap held at one, constant
// [RULE_05] Drive address as master, accept as slave
// [RULE_06] Data bus driven or received by direction
// [RULE_07] Read strobe on reads, not SDRAM
// [RULE_08] Slave read strobe marks internal reads
// [RULE_09] Only bus master drives strobes
// [RULE_10] Strobes change with address
// [RULE_11] Low write strobe on even or agent writes
// [RULE_12] Low write strobe on 32-bit zone writes
// [RULE_13] External master strobes low word writes
// [RULE_14] Slave low write strobe marks internal writes
// [RULE_15] Launch and sample on rising clock
module epb_dev #(
  parameter int FIFO_DEPTH = `EPB_FIFO_DEPTH,
  parameter int MEM_WORDS = `EPB_MEM_WORDS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Strap and mastership
  input wire logic system_clock_freq_strap,
  input wire logic bus_grant,
  // Outbound requests
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_zone32,
  input wire logic req_agent,
  input wire logic req_sdram,
  input wire logic [`EPB_ADDR_W-1:0] req_addr,
  input wire logic [`EPB_DATA_W-1:0] req_data,
  // Read results
  output logic resp_valid,
  output logic [`EPB_DATA_W-1:0] resp_data,
  // Local view of internal memory and strap fault flag
  input wire logic [$clog2(MEM_WORDS)-1:0] local_addr,
  output logic [`EPB_DATA_W-1:0] local_data,
  output logic strap_fault,
  // Bus pins
  epb_if.dev bus
);
  localparam int MAW = $clog2(MEM_WORDS);
  localparam int QW = 4 + `EPB_ADDR_W + `EPB_DATA_W;
  typedef struct packed {
    epb_pkg::epb_dev_state_e state;
    logic grant_meta;
    logic grant_sync;
    logic strap_taken;
    logic strap_fault;
    logic own;
    logic [`EPB_ADDR_W-1:0] addr_o;
    logic addr_oe;
    logic [`EPB_DATA_W-1:0] data_o;
    logic data_oe;
    logic rd_n_o;
    logic wrl_n_o;
    logic ctl_oe;
    logic is_read;
    logic resp_valid;
    logic [`EPB_DATA_W-1:0] resp_data;
    logic [MEM_WORDS-1:0][`EPB_DATA_W-1:0] mem;
    logic [`EPB_DATA_W-1:0] local_data;
  } epb_dev_s;
  epb_dev_s s;
  epb_dev_s next_s;
  logic q_valid;
  logic q_ready;
  logic [QW-1:0] q_data;
  logic q_write;
  logic q_zone32;
  logic q_agent;
  logic q_sdram;
  logic [`EPB_ADDR_W-1:0] q_addr;
  logic [`EPB_DATA_W-1:0] q_wdata;
  logic slave_hit;
  logic [MAW-1:0] slave_idx;

  // Memory must be at least two words and a power of two
  if (MEM_WORDS < 2 || (MEM_WORDS & (MEM_WORDS - 1)) != 0) begin : g_chk
    $error("epb_dev: MEM_WORDS must be a power of two of at least 2");
  end

  // Request queue, drained only while this end owns the bus
  epb_fifo #(
    .WIDTH(QW),
    .DEPTH(FIFO_DEPTH)
  ) u_queue (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data({req_write, req_zone32, req_agent, req_sdram, req_addr, req_data}),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_data)
  );

  assign {q_write, q_zone32, q_agent, q_sdram, q_addr, q_wdata} = q_data;
  assign q_ready = (s.state == epb_pkg::EPB_DEV_IDLE) && s.own && q_valid;
  // Slave address decode: internal memory sits at the bottom of the space
  assign slave_hit = (bus.bus_address[`EPB_ADDR_W-1:MAW] == '0);
  assign slave_idx = bus.bus_address[MAW-1:0];

  // Pins and user outputs come straight from the state register
  assign bus.dev_addr_o = s.addr_o;
  assign bus.dev_addr_oe = s.addr_oe;
  assign bus.dev_data_o = s.data_o;
  assign bus.dev_data_oe = s.data_oe;
  assign bus.dev_rd_n_o = s.rd_n_o;
  assign bus.dev_wrl_n_o = s.wrl_n_o;
  assign bus.dev_ctl_oe = s.ctl_oe;
  assign resp_valid = s.resp_valid;
  assign resp_data = s.resp_data;
  assign local_data = s.local_data;
  assign strap_fault = s.strap_fault;

  // Next-state logic for master sequencer, slave port and strap capture
  always_comb begin
    next_s = s;
    // Grant passes through two flops; only the second is read
    next_s.grant_meta = bus_grant; // RULE_01
    next_s.grant_sync = s.grant_meta; // RULE_01
    // Strap caught once after reset; a wrong level keeps mastering off
    if (!s.strap_taken) begin
      next_s.strap_taken = 1'b1;
      next_s.strap_fault = (system_clock_freq_strap != `EPB_STRAP_REQ); // RULE_04
    end
    next_s.resp_valid = 1'b0;
    next_s.local_data = s.mem[local_addr];
    // Mastership changes only between transfers
    if (s.state == epb_pkg::EPB_DEV_IDLE) begin
      next_s.own = s.grant_sync & s.strap_taken & ~s.strap_fault;
    end
    next_s.addr_oe = next_s.own; // RULE_05
    next_s.ctl_oe = next_s.own; // RULE_09
    next_s.data_oe = 1'b0;
    unique case (s.state)
      epb_pkg::EPB_DEV_IDLE: begin
        next_s.rd_n_o = `EPB_STROBE_OFF;
        next_s.wrl_n_o = `EPB_STROBE_OFF;
        if (q_ready) begin
          // Address and strobes load in the same edge
          next_s.state = epb_pkg::EPB_DEV_STROBE;
          next_s.addr_o = q_addr; // RULE_10
          next_s.is_read = ~q_write;
          next_s.rd_n_o = (q_write || q_sdram) ? `EPB_STROBE_OFF : `EPB_STROBE_ON; // RULE_07
          if (q_write && (q_zone32 || q_agent || !q_addr[0])) begin // RULE_11 RULE_12
            next_s.wrl_n_o = `EPB_STROBE_ON;
          end
          next_s.data_o = q_wdata; // RULE_06
          next_s.data_oe = q_write; // RULE_06
        end
      end
      epb_pkg::EPB_DEV_STROBE: begin
        // Read data is sampled at the edge that ends the strobe cycle
        next_s.state = epb_pkg::EPB_DEV_GAP;
        next_s.rd_n_o = `EPB_STROBE_OFF;
        next_s.wrl_n_o = `EPB_STROBE_OFF;
        if (s.is_read) begin
          next_s.resp_valid = 1'b1;
          next_s.resp_data = bus.bus_data; // RULE_06 RULE_15
        end
      end
      epb_pkg::EPB_DEV_GAP: begin
        // One quiet cycle lets the slave release the data bus
        next_s.state = epb_pkg::EPB_DEV_IDLE;
      end
      default: begin
        next_s.state = epb_pkg::EPB_DEV_IDLE;
      end
    endcase
    // Slave side: strobes from another master reach internal memory
    if (!s.own && !s.ctl_oe) begin
      if (bus.write_low_strobe_n == `EPB_STROBE_ON && slave_hit) begin // RULE_14
        next_s.mem[slave_idx][`EPB_LOW_W-1:0] = bus.bus_data[`EPB_LOW_W-1:0]; // RULE_13
      end
      if (bus.rd_n == `EPB_STROBE_ON && slave_hit) begin // RULE_08
        next_s.data_o = s.mem[slave_idx];
        next_s.data_oe = 1'b1; // RULE_06
      end
    end
  end

  // State register; reset releases every pin and idles the sequencer
  always_ff @(posedge core_clk or posedge rst) begin // RULE_15
    if (rst) begin
      s <= '0; // RULE_02 RULE_03
      s.rd_n_o <= `EPB_STROBE_OFF;
      s.wrl_n_o <= `EPB_STROBE_OFF;
      s.state <= epb_pkg::EPB_DEV_IDLE; // RULE_03
    end else begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// >>> core/epb_host.sv
// Purpose: Host end of the external port, master toward the processor
// Assumes: host_owns is a synchronous level given by the arbitration outside
// Notes: One transfer at a time; reads wait one cycle for the slave's data
`include "epb_map.svh"
`timescale 1ns/1ps
`default_nettype none
module epb_host (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Mastership
  input wire logic host_owns,
  // Commands
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [`EPB_ADDR_W-1:0] cmd_addr,
  input wire logic [`EPB_DATA_W-1:0] cmd_data,
  // Read results
  output logic resp_valid,
  output logic [`EPB_DATA_W-1:0] resp_data,
  // Bus pins
  epb_if.host bus
);
  typedef struct packed {
    epb_pkg::epb_host_state_e state;
    logic own;
    logic cmd_ready;
    logic [`EPB_ADDR_W-1:0] addr_o;
    logic addr_oe;
    logic [`EPB_DATA_W-1:0] data_o;
    logic data_oe;
    logic rd_n_o;
    logic wrl_n_o;
    logic ctl_oe;
    logic is_read;
    logic resp_valid;
    logic [`EPB_DATA_W-1:0] resp_data;
  } epb_host_s;
  epb_host_s s;
  epb_host_s next_s;
  logic take;

  assign take = cmd_valid & s.cmd_ready;
  assign cmd_ready = s.cmd_ready;
  assign resp_valid = s.resp_valid;
  assign resp_data = s.resp_data;
  assign bus.host_addr_o = s.addr_o;
  assign bus.host_addr_oe = s.addr_oe;
  assign bus.host_data_o = s.data_o;
  assign bus.host_data_oe = s.data_oe;
  assign bus.host_rd_n_o = s.rd_n_o;
  assign bus.host_wrl_n_o = s.wrl_n_o;
  assign bus.host_ctl_oe = s.ctl_oe;

  // Sequencer: strobe cycle, then a wait cycle in which a read is sampled
  always_comb begin
    next_s = s;
    next_s.resp_valid = 1'b0;
    next_s.data_oe = 1'b0;
    next_s.rd_n_o = `EPB_STROBE_OFF;
    next_s.wrl_n_o = `EPB_STROBE_OFF;
    if (s.state == epb_pkg::EPB_HOST_IDLE) begin
      next_s.own = host_owns;
    end
    next_s.addr_oe = next_s.own;
    next_s.ctl_oe = next_s.own; // RULE_09
    next_s.cmd_ready = 1'b0;
    unique case (s.state)
      epb_pkg::EPB_HOST_IDLE: begin
        next_s.cmd_ready = next_s.own & ~take;
        if (take) begin
          next_s.state = epb_pkg::EPB_HOST_STROBE;
          next_s.addr_o = cmd_addr; // RULE_10
          next_s.is_read = ~cmd_write;
          next_s.rd_n_o = cmd_write ? `EPB_STROBE_OFF : `EPB_STROBE_ON;
          next_s.wrl_n_o = cmd_write ? `EPB_STROBE_ON : `EPB_STROBE_OFF; // RULE_13
          next_s.data_o = cmd_data; // RULE_06
          next_s.data_oe = cmd_write; // RULE_06
        end
      end
      epb_pkg::EPB_HOST_STROBE: begin
        next_s.state = epb_pkg::EPB_HOST_WAIT;
      end
      epb_pkg::EPB_HOST_WAIT: begin
        // Slave drives its answer in this cycle
        next_s.state = epb_pkg::EPB_HOST_IDLE;
        next_s.cmd_ready = s.own & host_owns;
        if (s.is_read) begin
          next_s.resp_valid = 1'b1;
          next_s.resp_data = bus.bus_data; // RULE_15
        end
      end
      default: begin
        next_s.state = epb_pkg::EPB_HOST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk or posedge rst) begin // RULE_15
    if (rst) begin
      s <= '0;
      s.rd_n_o <= `EPB_STROBE_OFF;
      s.wrl_n_o <= `EPB_STROBE_OFF;
      s.state <= epb_pkg::EPB_HOST_IDLE;
    end else begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// >>> bench/epb_bus_checker.sv
// Purpose: Concurrent checks on the wires shared by the two port ends
// Assumes: Inputs come straight from the interface; rst is active high
// Notes: Only the interface joining the two design ends is watched
`include "epb_map.svh"
`timescale 1ns/1ps
`default_nettype none
module epb_bus_checker #(
  parameter int MEM_WORDS = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Processor end drivers
  input wire logic [`EPB_ADDR_W-1:0] dev_addr_o,
  input wire logic dev_addr_oe,
  input wire logic dev_data_oe,
  input wire logic dev_rd_n_o,
  input wire logic dev_wrl_n_o,
  input wire logic dev_ctl_oe,
  // Host end drivers
  input wire logic host_data_oe,
  input wire logic host_rd_n_o,
  input wire logic host_wrl_n_o,
  input wire logic host_ctl_oe,
  // Resolved wires
  input wire logic [`EPB_ADDR_W-1:0] bus_address,
  input wire logic rd_n
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // Address falls in the processor's internal window while it is not mastering
  logic slave_hit;
  assign slave_hit = (bus_address < MEM_WORDS) && !dev_ctl_oe;

  // Pin enables and strobe levels straight after reset
  pins_free_a: assert property ($fell(rst) |-> !(dev_addr_oe || dev_data_oe || dev_ctl_oe)
    && !(host_data_oe || host_ctl_oe)) else $error("Pin driven at reset release");
  strobes_idle_a: assert property ($fell(rst) |-> dev_rd_n_o && dev_wrl_n_o
    && host_rd_n_o && host_wrl_n_o) else $error("Strobe not idle at reset release");
  // Mastership and addressing
  one_master_a: assert property (!(dev_ctl_oe && host_ctl_oe))
    else $error("Both ends drive strobes");
  addr_owner_a: assert property (dev_ctl_oe |-> dev_addr_oe)
    else $error("Strobes driven without address");
  // Slave side answers
  slave_answer_a: assert property (!rd_n && host_ctl_oe && slave_hit |=> dev_data_oe)
    else $error("No slave data after read strobe");
  slave_cause_a: assert property (dev_data_oe && !dev_ctl_oe |->
    $past(rd_n) == 1'b0 && $past(slave_hit)) else $error("Slave data without read");
  // Master side strobes
  wrl_pulse_a: assert property (!dev_wrl_n_o && dev_ctl_oe |=>
    dev_wrl_n_o && dev_rd_n_o && $stable(dev_addr_o)) else $error("Write strobe misaligned");
  rd_pulse_a: assert property (!dev_rd_n_o && dev_ctl_oe |->
    !dev_data_oe ##1 (dev_rd_n_o && $stable(dev_addr_o))) else $error("Read strobe misformed");
  data_once_a: assert property (dev_data_oe && dev_ctl_oe |=> !dev_data_oe)
    else $error("Write data held too long");
  host_wrl_a: assert property (!host_wrl_n_o && host_ctl_oe |-> host_data_oe ##1 host_wrl_n_o)
    else $error("Host write strobe misformed");
  host_gap_a: assert property (!host_rd_n_o && host_ctl_oe |=> host_rd_n_o [*2])
    else $error("Host read strobe spacing");
  // Main scenarios reached
  host_read_c: cover property (!host_rd_n_o && host_ctl_oe);
  dev_write_c: cover property (!dev_wrl_n_o && dev_ctl_oe);
  dev_read_c: cover property (!dev_rd_n_o && dev_ctl_oe);
  slave_data_c: cover property (dev_data_oe && !dev_ctl_oe);
endmodule
`default_nettype wire

// >>> bench/epb_tb.sv
// Purpose: Self-checking bench for both port ends joined by one interface
// Assumes: Inputs change at the falling clock edge
// Notes: A second processor end with a bad strap sits on a bus of its own
`include "epb_map.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk, rst, host_owns, bus_grant, req_valid, req_ready, req_write, req_zone32;
  logic req_agent, req_sdram, dev_resp_valid, strap_fault, strap2_fault;
  logic cmd_valid, cmd_ready, cmd_write, host_resp_valid;
  logic [31:0] req_addr, cmd_addr;
  logic [63:0] req_data, cmd_data, dev_resp_data, host_resp_data, local_data;
  logic [$clog2(`EPB_MEM_WORDS)-1:0] local_addr;
  int bad_count = 0, num_checks = 0, wrl_cnt = 0, rd_cnt = 0, stray_cnt = 0;
  epb_if bus_if();
  epb_if bus2_if();
  // Host side of the fault bus stays released
  assign bus2_if.host_addr_oe = 1'b0;
  assign bus2_if.host_data_oe = 1'b0;
  assign bus2_if.host_ctl_oe = 1'b0;
  assign bus2_if.host_addr_o = '0;
  assign bus2_if.host_data_o = '0;
  assign bus2_if.host_rd_n_o = 1'b1;
  assign bus2_if.host_wrl_n_o = 1'b1;
  epb_dev epb_dev_inst (.core_clk(core_clk), .rst(rst), .system_clock_freq_strap(1'b1),
    .bus_grant(bus_grant), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_zone32(req_zone32), .req_agent(req_agent), .req_sdram(req_sdram), .req_addr(req_addr),
    .req_data(req_data), .resp_valid(dev_resp_valid), .resp_data(dev_resp_data),
    .local_addr(local_addr), .local_data(local_data), .strap_fault(strap_fault), .bus(bus_if.dev));
  epb_dev epb_dev_fault_inst (.core_clk(core_clk), .rst(rst), .system_clock_freq_strap(1'b0),
    .bus_grant(bus_grant), .req_valid(req_valid), .req_ready(), .req_write(req_write),
    .req_zone32(req_zone32), .req_agent(req_agent), .req_sdram(req_sdram), .req_addr(req_addr),
    .req_data(req_data), .resp_valid(), .resp_data(), .local_addr(local_addr), .local_data(),
    .strap_fault(strap2_fault), .bus(bus2_if.dev));
  epb_host epb_host_inst (.core_clk(core_clk), .rst(rst), .host_owns(host_owns),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .resp_valid(host_resp_valid), .resp_data(host_resp_data),
    .bus(bus_if.host));
  epb_bus_checker #(.MEM_WORDS(`EPB_MEM_WORDS)) epb_bus_checker_inst (.core_clk(core_clk),
    .rst(rst), .dev_addr_o(bus_if.dev_addr_o), .dev_addr_oe(bus_if.dev_addr_oe),
    .dev_data_oe(bus_if.dev_data_oe), .dev_rd_n_o(bus_if.dev_rd_n_o),
    .dev_wrl_n_o(bus_if.dev_wrl_n_o), .dev_ctl_oe(bus_if.dev_ctl_oe),
    .host_data_oe(bus_if.host_data_oe), .host_rd_n_o(bus_if.host_rd_n_o),
    .host_wrl_n_o(bus_if.host_wrl_n_o), .host_ctl_oe(bus_if.host_ctl_oe),
    .bus_address(bus_if.bus_address), .rd_n(bus_if.rd_n));
  // Clock source
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Strobe counters on the main bus, drive counter on the fault bus
  always @(posedge core_clk) begin
    if (bus_if.dev_ctl_oe && !bus_if.write_low_strobe_n) wrl_cnt++;
    if (bus_if.dev_ctl_oe && !bus_if.rd_n) rd_cnt++;
    if (bus2_if.dev_ctl_oe || bus2_if.dev_addr_oe) stray_cnt++;
  end
  task automatic complete_run();
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One host transfer; waits for ready and for read data under a bound
  task automatic host_op(input logic wr, input logic [31:0] a, input logic [63:0] d,
                         output logic [63:0] q);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    chk("cmd ready", 1'b1, cmd_ready);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr = a;
    cmd_data = d;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (!wr && host_resp_valid !== 1'b1 && n < 10) begin
      @(negedge core_clk);
      n++;
    end
    if (!wr) chk("host resp valid", 1'b1, host_resp_valid);
    q = host_resp_data;
  endtask
  task automatic t_reset_state();
    chk("oe", 6'h00, {bus_if.dev_addr_oe, bus_if.dev_data_oe, bus_if.dev_ctl_oe,
      bus_if.host_addr_oe, bus_if.host_data_oe, bus_if.host_ctl_oe});
    chk("strobes", 2'h3, {bus_if.rd_n, bus_if.write_low_strobe_n});
    chk("idle", 3'h0, {req_ready, cmd_ready, strap_fault});
  endtask
  task automatic t_host_slave();
    logic [63:0] q;
    host_op(1'b1, 32'h0000_0003, 64'hA5A5_0000_1234_5678, q);
    host_op(1'b1, 32'h0000_0013, 64'h0000_0000_DEAD_BEEF, q);
    host_op(1'b0, 32'h0000_0003, 64'h0, q);
    chk("host read", 32'h1234_5678, q[31:0]);
    local_addr = 4'h3;
    @(negedge core_clk);
    chk("local word", 32'h1234_5678, local_data[31:0]);
    host_owns = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask
  task automatic t_fill_drain();
    logic [5:0] k;
    int ew, er, es, n;
    ew = 0;
    er = 0;
    es = 0;
    n = 0;
    for (int i = 0; i < 33; i++) begin
      k = 6'(i);
      req_valid = 1'b1;
      req_write = (k[1:0] != 2'h3);
      req_zone32 = k[2];
      req_agent = k[3];
      req_sdram = k[4];
      req_addr = 32'(k);
      req_data = 64'(k);
      chk("req ready", (i < 32), req_ready);
      if (i < 32 && req_write && (k[2] || k[3] || !k[0])) ew++;
      if (i < 32 && !req_write && !k[4]) er++;
      if (i < 32 && !req_write) es++;
      @(negedge core_clk);
    end
    req_valid = 1'b0;
    bus_grant = 1'b1;
    repeat (120) begin
      @(negedge core_clk);
      if (dev_resp_valid === 1'b1) begin
        n++;
        chk("dev read data", 64'h0, dev_resp_data);
      end
    end
    chk("write low count", 32'(ew), 32'(wrl_cnt));
    chk("read count", 32'(er), 32'(rd_cnt));
    chk("read answers", 32'(es), 32'(n));
    chk("last address", 32'h1F, bus_if.bus_address);
    chk("fault bus", 32'h0, 32'(stray_cnt));
    chk("strap flags", 2'h1, {strap_fault, strap2_fault});
    chk("drained", 1'b1, req_ready);
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    host_owns = 1'b1;
    bus_grant = 1'b0;
    {req_valid, req_write, req_zone32, req_agent, req_sdram} = '0;
    {req_addr, req_data, cmd_addr, cmd_data} = '0;
    {cmd_valid, cmd_write} = '0;
    local_addr = '0;
    repeat (3) @(negedge core_clk);
    t_reset_state();
    rst = 1'b0;
    @(negedge core_clk);
    t_host_slave();
    t_fill_drain();
    complete_run();
  end
  // Watchdog
  initial begin
    #(50 * 600);
    bad_count++;
    complete_run();
  end
endmodule
`default_nettype wire
